// *** host_port_consts.vh ***
// Purpose: constants for the graphics display host port
// Assumes: 100 MHz core clock, host strobes synchronous to it
// Notes: definitions only
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH
`define CLK_PERIOD_NS 10
`define READY_LEAD_NS 3500
`define READY_LEAD_CYC ((`READY_LEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LAST_ROW 8'd128
`define ROW_CYCLES 16'h0190
`define FRAME_ROWS 8'd140
`define STYLE_8080 1'b0
`define STYLE_6800 1'b1
`define ACC_NONE 3'h0
`define ACC_STATUS_RD 3'h1
`define ACC_DATA_RD 3'h2
`define ACC_DATA_WR 3'h3
`define ACC_CMD_WR 3'h4
`define IRQ_WIDTH 4
`define IRQ_DATA_WR 0
`define IRQ_CMD_WR 1
`define IRQ_READY_RISE 2
`define IRQ_READY_FALL 3
`define ADR_STATUS 2'h0
`define ADR_MASK 2'h1
`define ADR_CTRL 2'h2
`define ADR_LAST 2'h3
`define STATUS_RESET 4'h0
`define MASK_RESET 4'h0
`define RESP_CLEAR_LEN 4'h8
`endif

// *** edge_detect.v ***
// Purpose: rise/fall pulse on a synchronous level, taken against a registered copy of it
// Assumes: input already synchronous to clk
// Notes: no latency, pulse comes in the same cycle the level changes
module edge_detect (
   clk,
   arst_n,
   level,
   rise,
   fall
);
   input wire clk;
   input wire arst_n;
   input wire level;
   output wire rise;
   output wire fall;
   reg prev_q;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level;
      end
   end
   assign rise = level & ~prev_q;
   assign fall = ~level & prev_q;
endmodule // edge_detect

// *** frame_timer.v ***
// Purpose: row/frame scan counter behind the ready window
// Assumes: fixed refresh timing
// Notes: ready drops a lead time ahead of row 0 of next frame
`include "host_port_consts.vh"
module frame_timer (
   clk,
   arst_n,
   clear_n,
   ready_d,
   row
);
   input wire clk;
   input wire arst_n;
   input wire clear_n;
   output reg ready_d;
   output wire [7:0] row;
   localparam [31:0] FRAME_CYC = `ROW_CYCLES * `FRAME_ROWS;
   localparam [31:0] DROP_AT = FRAME_CYC - `READY_LEAD_CYC;
   localparam [31:0] RISE_AT = `ROW_CYCLES * `LAST_ROW;
   reg [31:0] cyc_q;
   reg [15:0] sub_q;
   reg [7:0] row_q;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cyc_q <= 32'h0;
         sub_q <= 16'h0;
         row_q <= 8'h0;
      end else if (!clear_n) begin
         cyc_q <= 32'h0;
         sub_q <= 16'h0;
         row_q <= 8'h0;
      end else if (cyc_q == FRAME_CYC - 32'h1) begin
         cyc_q <= 32'h0;
         sub_q <= 16'h0;
         row_q <= 8'h0;
      end else begin
         cyc_q <= cyc_q + 32'h1;
         if (sub_q == `ROW_CYCLES - 16'h1) begin
            sub_q <= 16'h0;
            row_q <= row_q + 8'h1;
         end else begin
            sub_q <= sub_q + 16'h1;
         end
      end
   end
   assign row = row_q;
   // high after row 128 loaded, low lead time before next row 0
   always @* begin
      ready_d = (cyc_q >= RISE_AT) && (cyc_q < DROP_AT) && clear_n;
   end
endmodule // frame_timer

// *** graphics_display_host_port.v ***
// Purpose: 8-bit host port of the graphics display, both bus styles
// Assumes: host pins synchronous to clk; strobes at least two cycles
// Notes: data_oe_n low while driving data out; registers on a side port
// How it works
// - 8080 style: write line low marks a write access.
// - 8080 style: data byte captured at the write strobe rising edge.
// - 6800 style: write line low writes, high reads.
// - controller clear low resets the embedded controller state.
// - 8080: select 0 read status, 1 read data, 0 write data, 1 command.
// - 6800: select with enable and direction picks the same four accesses.
// - pattern test mode high sets test_active one cycle later.
// - bus style select low means 8080, high means 6800.
// - read line: 8080 active-low read strobe, 6800 active-high enable.
`include "host_port_consts.vh"
module graphics_display_host_port (
   clk,
   arst_n,
   cs_n,
   register_select,
   rd_n_e,
   wr_n_rw,
   bus_style_select,
   controller_clear_n,
   pattern_test_mode,
   data_in,
   data_out,
   data_oe_n,
   ready,
   test_active,
   cmd_valid,
   cmd_is_data,
   cmd_byte,
   status_byte,
   rdata_byte,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   irq
);
   input wire clk;
   input wire arst_n;
   input wire cs_n;
   input wire register_select;
   input wire rd_n_e;
   input wire wr_n_rw;
   input wire bus_style_select;
   input wire controller_clear_n;
   input wire pattern_test_mode;
   input wire [7:0] data_in;
   output reg [7:0] data_out;
   output reg data_oe_n;
   output reg ready;
   output reg test_active;
   output reg cmd_valid;
   output reg cmd_is_data;
   output reg [7:0] cmd_byte;
   input wire [7:0] status_byte;
   input wire [7:0] rdata_byte;
   input wire [1:0] reg_addr;
   input wire [7:0] reg_wdata;
   input wire reg_wr;
   input wire reg_rd;
   output reg [7:0] reg_rdata;
   output reg irq;

   reg [7:0] wr_hold_q;
   reg rs_hold_q;
   reg [3:0] status_q;
   reg [3:0] mask_q;
   reg [7:0] last_cmd_q;
   reg style_q;
   reg [2:0] acc_q;
   wire sel;
   reg wr_strobe;
   reg rd_active;
   reg wr_pending;
   reg [3:0] status_d;
   reg [7:0] rd_mux;
   wire wr_rise;
   wire e_fall;
   wire ready_d;
   wire ready_rise;
   wire ready_fall;
   wire [7:0] row;
   reg wr_done;
   reg [2:0] acc_d;
   reg [3:0] events;

   // style caught by clock after reset, since the strap is static
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         style_q <= `STYLE_8080;
      end else begin
         style_q <= bus_style_select;
      end
   end

   assign sel = ~cs_n;

   always @* begin
      wr_strobe = 1'b0;
      if (sel) begin
         if (style_q == `STYLE_8080) begin
            wr_strobe = ~wr_n_rw;
         end else begin
            // 6800 writes only while enable is high
            wr_strobe = rd_n_e & ~wr_n_rw;
         end
      end
   end

   always @* begin
      rd_active = 1'b0;
      if (sel) begin
         if (style_q == `STYLE_8080) begin
            rd_active = ~rd_n_e & wr_n_rw;
         end else begin
            rd_active = rd_n_e & wr_n_rw;
         end
      end
   end

   // decode of access type
   always @* begin
      acc_d = `ACC_NONE;
      if (style_q == `STYLE_8080) begin
         if (sel && !rd_n_e && wr_n_rw) begin
            acc_d = register_select ? `ACC_DATA_RD : `ACC_STATUS_RD;
         end else if (sel && rd_n_e && !wr_n_rw) begin
            acc_d = register_select ? `ACC_CMD_WR : `ACC_DATA_WR;
         end
      end else begin
         if (sel && rd_n_e) begin
            if (wr_n_rw) begin
               acc_d = register_select ? `ACC_DATA_RD : `ACC_STATUS_RD;
            end else begin
               acc_d = register_select ? `ACC_CMD_WR : `ACC_DATA_WR;
            end
         end
      end
   end

   edge_detect u_wr_edge (
      .clk(clk),
      .arst_n(arst_n),
      .level(wr_n_rw),
      .rise(wr_rise),
      .fall()
   );

   edge_detect u_e_edge (
      .clk(clk),
      .arst_n(arst_n),
      .level(rd_n_e),
      .rise(),
      .fall(e_fall)
   );

   always @* begin
      wr_pending = (acc_q == `ACC_DATA_WR) || (acc_q == `ACC_CMD_WR);
      wr_done = 1'b0;
      if (style_q == `STYLE_8080) begin
         wr_done = wr_rise & wr_pending;
      end else begin
         // 6800 data is taken as enable falls
         wr_done = e_fall & wr_pending;
      end
   end

   frame_timer u_frame (
      .clk(clk),
      .arst_n(arst_n),
      .clear_n(controller_clear_n),
      .ready_d(ready_d),
      .row(row)
   );

   edge_detect u_ready_edge (
      .clk(clk),
      .arst_n(arst_n),
      .level(ready_d),
      .rise(ready_rise),
      .fall(ready_fall)
   );

   always @* begin
      events = 4'h0;
      events[`IRQ_DATA_WR] = cmd_valid & cmd_is_data;
      events[`IRQ_CMD_WR] = cmd_valid & ~cmd_is_data;
      events[`IRQ_READY_RISE] = ready_rise;
      events[`IRQ_READY_FALL] = ready_fall;
   end

   // host access path
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_q <= `ACC_NONE;
         wr_hold_q <= 8'h0;
         rs_hold_q <= 1'b0;
         cmd_valid <= 1'b0;
         cmd_is_data <= 1'b0;
         cmd_byte <= 8'h0;
         last_cmd_q <= 8'h0;
      end else if (!controller_clear_n) begin
         acc_q <= `ACC_NONE;
         cmd_valid <= 1'b0;
         cmd_is_data <= 1'b0;
         last_cmd_q <= 8'h0;
      end else begin
         cmd_valid <= 1'b0;
         if (acc_d != `ACC_NONE) begin
            acc_q <= acc_d;
         end else if (!wr_done) begin
            acc_q <= `ACC_NONE;
         end
         // sample data while strobe held, so value at the edge wins
         if (wr_strobe) begin
            wr_hold_q <= data_in;
            rs_hold_q <= register_select;
         end
         if (wr_done) begin
            cmd_valid <= 1'b1;
            cmd_is_data <= ~rs_hold_q;
            cmd_byte <= wr_hold_q;
            if (rs_hold_q) begin
               last_cmd_q <= wr_hold_q;
            end
            acc_q <= `ACC_NONE;
         end
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         data_out <= 8'h0;
         data_oe_n <= 1'b1;
      end else if (!controller_clear_n) begin
         // released while the controller is held in clear
         data_oe_n <= 1'b1;
      end else begin
         data_oe_n <= ~rd_active;
         // byte kept between reads, only the enable matters
         if (acc_d == `ACC_STATUS_RD) begin
            data_out <= status_byte;
         end else if (acc_d == `ACC_DATA_RD) begin
            data_out <= rdata_byte;
         end
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ready <= 1'b0;
      end else begin
         ready <= ready_d;
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         test_active <= 1'b0;
      end else begin
         test_active <= pattern_test_mode;
      end
   end

   // set wins over write-one clear, so no event is lost
   always @* begin
      status_d = status_q | events;
      if (reg_wr && reg_addr == `ADR_STATUS) begin
         status_d = (status_q & ~reg_wdata[3:0]) | events;
      end
   end

   // read mux, zero when nothing is read
   always @* begin
      rd_mux = 8'h0;
      if (reg_rd) begin
         case (reg_addr)
            `ADR_STATUS: begin
               rd_mux = {4'h0, status_q};
            end
            `ADR_MASK: begin
               rd_mux = {4'h0, mask_q};
            end
            `ADR_CTRL: begin
               rd_mux = {4'h0, test_active, ready, style_q, acc_q != `ACC_NONE};
            end
            `ADR_LAST: begin
               rd_mux = last_cmd_q;
            end
            default: begin
               rd_mux = 8'h0;
            end
         endcase
      end
   end

   // mask register
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mask_q <= `MASK_RESET;
      end else if (reg_wr && reg_addr == `ADR_MASK) begin
         mask_q <= reg_wdata[3:0];
      end
   end

   // side register port and interrupt
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         status_q <= `STATUS_RESET;
         reg_rdata <= 8'h0;
         irq <= 1'b0;
      end else begin
         status_q <= status_d;
         reg_rdata <= rd_mux;
         // one cycle lag on irq keeps it a clean flop output
         irq <= |(status_q & mask_q);
      end
   end
endmodule // graphics_display_host_port

// *** host_port_chk_asserts.sv ***
// Purpose: port checks for the display host port
// Assumes: style strap moves only in reset
// Notes: read latency one cycle, commit within two
module host_port_chk (
   input wire clk,
   input wire arst_n,
   input wire cs_n,
   input wire register_select,
   input wire rd_n_e,
   input wire wr_n_rw,
   input wire bus_style_select,
   input wire controller_clear_n,
   input wire pattern_test_mode,
   input wire [7:0] data_out,
   input wire data_oe_n,
   input wire ready,
   input wire test_active,
   input wire cmd_valid,
   input wire [7:0] status_byte,
   input wire [7:0] rdata_byte
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire sel = !cs_n && controller_clear_n;
   wire rd8 = sel && !bus_style_select && !rd_n_e && wr_n_rw;
   wire rd6 = sel && bus_style_select && rd_n_e && wr_n_rw;
   a_read_8080: assert property (rd8 |=> !data_oe_n && data_out ==
      ($past(register_select) ? rdata_byte : status_byte)) else $error("8080 read");
   a_read_6800: assert property (rd6 |=> !data_oe_n && data_out ==
      ($past(register_select) ? rdata_byte : status_byte)) else $error("6800 read");
   a_write_8080: assert property ($rose(wr_n_rw) && $past(sel) && !bus_style_select
      |-> ##[1:2] cmd_valid) else $error("8080 commit");
   a_write_6800: assert property ($fell(rd_n_e) && $past(sel && !wr_n_rw)
      && bus_style_select |-> ##[1:2] cmd_valid) else $error("6800 commit");
   a_cs_release: assert property (cs_n |=> data_oe_n) else $error("bus held");
   a_cs_refuse: assert property (cs_n [*4] |=> !cmd_valid) else $error("no select");
   a_clear_hold: assert property (!controller_clear_n |=> !ready && !cmd_valid)
      else $error("clear ignored");
   a_test_follow: assert property (pattern_test_mode [*2] |-> test_active)
      else $error("test mode");
   cover property (cmd_valid);
   cover property (!data_oe_n && bus_style_select);
   cover property ($fell(ready));
endmodule // host_port_chk
bind graphics_display_host_port host_port_chk u_chk (.clk(clk), .arst_n(arst_n),
   .cs_n(cs_n), .register_select(register_select), .rd_n_e(rd_n_e), .wr_n_rw(wr_n_rw),
   .bus_style_select(bus_style_select), .controller_clear_n(controller_clear_n),
   .pattern_test_mode(pattern_test_mode), .data_out(data_out), .data_oe_n(data_oe_n),
   .ready(ready), .test_active(test_active), .cmd_valid(cmd_valid),
   .status_byte(status_byte), .rdata_byte(rdata_byte));

// *** host_bus_model.sv ***
// Purpose: host processor on the display port
// Assumes: strobes three cycles, gaps at least three
// Notes: data lines show the inverse once hold ends
module host_bus_model (
   input wire clk,
   input wire style,
   output logic cs_n = 1'b1,
   output logic register_select = 1'b0,
   output logic rd_n_e = 1'b1,
   output logic wr_n_rw = 1'b1,
   output logic [7:0] data_in = 8'h00,
   input wire [7:0] data_out,
   input wire data_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   task automatic idle();
      cs_n <= 1'b1;
      rd_n_e <= !style;
      wr_n_rw <= 1'b1;
   endtask
   task automatic wr(input logic sel_n, input logic rs, input logic [7:0] d);
      @(posedge clk);
      cs_n <= sel_n;
      register_select <= rs;
      data_in <= ~d;
      wr_n_rw <= 1'b0;
      rd_n_e <= 1'b1;
      @(posedge clk);
      data_in <= d;
      repeat (2) @(posedge clk);
      if (style) rd_n_e <= 1'b0;
      else wr_n_rw <= 1'b1;
      @(posedge clk);
      idle();
      data_in <= ~d;
      repeat (2) @(posedge clk);
   endtask
   task automatic rd(input logic rs, output logic [7:0] d, output logic oe_n);
      @(posedge clk);
      cs_n <= 1'b0;
      register_select <= rs;
      rd_n_e <= style;
      repeat (3) @(posedge clk);
      d = data_out;
      oe_n = data_oe_n;
      idle();
      repeat (2) @(posedge clk);
   endtask
endmodule // host_bus_model

// *** graphics_display_host_port_tb_top.sv ***
// Purpose: bench for the display host port
// Assumes: frame of 400 x 140 cycles
// Notes: frame is waited up to the ready drop, so the run is long
module graphics_display_host_port_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, arst_n = 1'b0, style = 1'b0, clear_n = 1'b1, test_mode = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, ov, last_is_data;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00, dv, last_byte;
   wire cs_n, rs, rd_n_e, wr_n_rw, oe_n, ready, test_active, cmd_valid, cmd_is_data, irq;
   wire [7:0] data_in, data_out, cmd_byte, reg_rdata;
   int n_cmd = 0, err_count = 0, n_tests = 0, i;
   always #5 clk = ~clk;
   always @(posedge clk) if (cmd_valid === 1'b1) begin
      last_byte <= cmd_byte;
      last_is_data <= cmd_is_data;
      n_cmd <= n_cmd + 1;
   end
   graphics_display_host_port DUT (.clk(clk), .arst_n(arst_n), .cs_n(cs_n),
      .register_select(rs), .rd_n_e(rd_n_e), .wr_n_rw(wr_n_rw), .bus_style_select(style),
      .controller_clear_n(clear_n), .pattern_test_mode(test_mode), .data_in(data_in),
      .data_out(data_out), .data_oe_n(oe_n), .ready(ready), .test_active(test_active),
      .cmd_valid(cmd_valid), .cmd_is_data(cmd_is_data), .cmd_byte(cmd_byte),
      .status_byte(8'h5a), .rdata_byte(8'ha5), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   host_bus_model host (.clk(clk), .style(style), .cs_n(cs_n), .register_select(rs),
      .rd_n_e(rd_n_e), .wr_n_rw(wr_n_rw), .data_in(data_in), .data_out(data_out),
      .data_oe_n(oe_n));
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic restart(input logic s);
      arst_n <= 1'b0;
      style <= s;
      @(posedge clk);
      host.idle();
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   task automatic wcmd(input logic sel_n, input logic ok, input logic rs, input logic [7:0] d);
      int n0;
      n0 = n_cmd;
      host.wr(sel_n, rs, d);
      chk("commits", 8'(n0 + ok), 8'(n_cmd));
      if (ok) chk("cmd byte", d, last_byte);
      if (ok) chk("cmd kind", {7'h0, !rs}, {7'h0, last_is_data});
   endtask
   task automatic rdc(input logic rs, input logic [7:0] e);
      host.rd(rs, dv, ov);
      chk("bus read", e, dv);
      chk("bus drive", 8'h00, {7'h0, ov});
   endtask
   task automatic rwr(input logic [1:0] a, input logic [7:0] d, input logic q);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      repeat (2) @(posedge clk);
      chk("irq", {7'h0, q}, {7'h0, irq});
   endtask
   task automatic rrd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      chk("reg", e, reg_rdata & m);
   endtask
   task automatic wait_ready(input logic lvl, input int bound);
      for (i = 0; i < bound && ready !== lvl; i++) @(posedge clk);
      chk("ready", {7'h0, lvl}, {7'h0, ready});
      if (ready !== lvl) conclude();
   endtask
   initial begin
      restart(1'b0);
      wcmd(1'b0, 1'b1, 1'b0, 8'h3c);
      wcmd(1'b0, 1'b1, 1'b1, 8'hc3);
      wcmd(1'b1, 1'b0, 1'b0, 8'h55);
      rdc(1'b0, 8'h5a);
      rdc(1'b1, 8'ha5);
      chk("release", 8'h01, {7'h0, oe_n});
      $display("test 8080 bus done");
      rrd(2'h0, 8'h03, 8'h03);
      rwr(2'h1, 8'h01, 1'b1);
      rwr(2'h0, 8'h01, 1'b0);
      rwr(2'h1, 8'h02, 1'b1);
      rwr(2'h0, 8'h02, 1'b0);
      rwr(2'h3, 8'h00, 1'b0);
      rrd(2'h3, 8'hff, 8'hc3);
      rrd(2'h2, 8'h02, 8'h00);
      $display("test registers done");
      // long wait: ready only rises late in the frame
      wait_ready(1'b1, 60000);
      rrd(2'h2, 8'h04, 8'h04);
      wait_ready(1'b0, 6000);
      rrd(2'h0, 8'h0c, 8'h0c);
      clear_n <= 1'b0;
      wcmd(1'b0, 1'b0, 1'b0, 8'h77);
      chk("cleared", 8'h00, {7'h0, ready});
      clear_n <= 1'b1;
      test_mode <= 1'b1;
      rrd(2'h2, 8'h08, 8'h08);
      chk("test active", 8'h01, {7'h0, test_active});
      test_mode <= 1'b0;
      $display("test frame done");
      restart(1'b1);
      chk("test idle", 8'h00, {7'h0, test_active});
      wcmd(1'b0, 1'b1, 1'b0, 8'h81);
      wcmd(1'b0, 1'b1, 1'b1, 8'h18);
      rdc(1'b0, 8'h5a);
      rdc(1'b1, 8'ha5);
      rrd(2'h2, 8'h02, 8'h02);
      $display("test 6800 bus done");
      conclude();
   end
endmodule // graphics_display_host_port_tb_top
